// ### rtl/hbr_pkg.sv
package hbr_pkg;
  // request-phase codes
  localparam logic [4:0] HBR_REQA_SPECIAL  = 5'h08;
  localparam logic [2:0] HBR_REQB_SPECIAL  = 3'h1;
  localparam logic [4:0] HBR_REQA_INTACK   = 5'h08;
  localparam logic [2:0] HBR_REQB_INTACK   = 3'h0;
  localparam logic [4:0] HBR_REQA_IORD     = 5'h10;
  localparam logic [4:0] HBR_REQA_IOWR     = 5'h11;
  localparam logic [4:0] HBR_REQA_MRI      = 5'h02;
  localparam logic [4:0] HBR_REQA_CODERD   = 5'h04;
  localparam logic [4:0] HBR_REQA_DATARD   = 5'h06;
  localparam logic [4:0] HBR_REQA_WB       = 5'h05;
  localparam logic [4:0] HBR_REQA_WR       = 5'h07;
  // special cycle type in byte_lane_enables
  localparam logic [7:0] HBR_SC_MGMT_ACK   = 8'h07;
  localparam int         HBR_SMM_BIT       = 7;
  // response status codes
  localparam logic [2:0] HBR_RS_IDLE       = 3'h0;
  localparam logic [2:0] HBR_RS_RETRY      = 3'h1;
  localparam logic [2:0] HBR_RS_NODATA     = 3'h5;
  localparam logic [2:0] HBR_RS_IMPWB      = 3'h6;
  localparam logic [2:0] HBR_RS_NORMAL     = 3'h7;
  // transfer lengths
  localparam logic [1:0] HBR_LEN_PARTIAL   = 2'h0;
  localparam logic [1:0] HBR_LEN_LINE      = 2'h2;
  localparam int         HBR_LINE_BEATS    = 4;
  localparam int         HBR_DATA_W        = 64;

  typedef enum logic [3:0] {
    HBR_ST_IDLE = 4'h1,
    HBR_ST_REQ  = 4'h2,
    HBR_ST_DATA = 4'h4,
    HBR_ST_RESP = 4'h8
  } hbr_state_t;

  function automatic logic hbr_is_special(input logic [4:0] a, input logic [4:0] b);
    return (a == HBR_REQA_SPECIAL) && (b[2:0] == HBR_REQB_SPECIAL);
  endfunction

  function automatic logic hbr_is_write(input logic [4:0] a);
    return (a == HBR_REQA_IOWR) || (a == HBR_REQA_WB) || (a == HBR_REQA_WR);
  endfunction
endpackage

// ### rtl/hbr_fsb_if.sv
`timescale 1ns/1ps
interface hbr_fsb_if;
  logic                          req_valid;
  logic [4:0]                    request_code_first_phase;
  logic [4:0]                    request_code_second_phase;
  logic [35:3]                   first_address_phase;
  logic [15:0]                   second_address_phase;
  logic                          locked;
  logic                          modified_line_hit;
  logic [hbr_pkg::HBR_DATA_W-1:0] wdata;
  logic                          wdata_valid;
  logic [2:0]                    response_status_code;
  logic [hbr_pkg::HBR_DATA_W-1:0] rdata;
  logic                          rdata_valid;
  logic                          busy;

  modport bridge (
    input  req_valid, request_code_first_phase, request_code_second_phase,
           first_address_phase, second_address_phase, locked, modified_line_hit,
           wdata, wdata_valid,
    output response_status_code, rdata, rdata_valid, busy
  );
  modport cpu (
    output req_valid, request_code_first_phase, request_code_second_phase,
           first_address_phase, second_address_phase, locked, modified_line_hit,
           wdata, wdata_valid,
    input  response_status_code, rdata, rdata_valid, busy
  );
endinterface

// ### rtl/hbr_bridge.sv
`timescale 1ns/1ps
// Behaviour
// - special cycle: first 01000, second xx001
// - first address phase ignored on special
// - special type from byte lanes [15:8]
// - special cycle posted, ends at once
// - processor enters management with type 07
// - bit7 accesses go to management space while management is open
// - ack with bit7 low closes management
// - idle 000; reads get normal 111
// - retry 001 when target is unavailable
// - writes, zero-length reads get no-data 101
// - modified snoop hit gets writeback 110
// - writeback response only in snooping variant
// - write plus writeback: two data transfers
// - never issue deferred reply
// - no snooping of peripheral-to-memory traffic
// - vector fetched via interrupt-acknowledge cycle
module hbr_bridge
  import hbr_pkg::*;
#(
  parameter bit SNOOP_VARIANT = 1'b1
) (
  // clock, reset, enable
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  // host bus
  hbr_fsb_if.bridge                  fsb,
  // target side
  input  wire logic                  i_target_busy,
  input  wire logic [HBR_DATA_W-1:0] i_target_rdata,
  output logic                       o_smm_open,
  output logic                       o_smm_access,
  output logic                       o_fwd_valid,
  output logic                       o_fwd_write,
  output logic                       o_wb_valid,
  output logic [HBR_DATA_W-1:0]      o_wb_data,
  output logic                       o_special_valid,
  output logic [7:0]                 o_special_type
);
  hbr_state_t            st_r, st_nxt;
  logic [2:0]            rs_r, rs_nxt;
  logic                  smm_r, smm_nxt;
  logic                  wr_r, wr_nxt;
  logic                  hit_r, hit_nxt;
  logic [2:0]            beats_r, beats_nxt;
  logic [2:0]            cnt_r, cnt_nxt;
  logic                  rv_r, rv_nxt;
  logic [HBR_DATA_W-1:0] rd_r, rd_nxt;
  logic                  wbv_r, wbv_nxt;
  logic [HBR_DATA_W-1:0] wbd_r, wbd_nxt;
  logic                  fv_r, fv_nxt;
  logic                  fw_r, fw_nxt;
  logic                  sa_r, sa_nxt;
  logic                  sv_r, sv_nxt;
  logic [7:0]            sty_r, sty_nxt;
  logic                  spec;
  logic                  zero_len;

  assign spec     = hbr_is_special(fsb.request_code_first_phase,
                                   fsb.request_code_second_phase);
  assign zero_len = (fsb.second_address_phase[15:8] == 8'h00);

  always_comb begin
    st_nxt    = st_r;
    rs_nxt    = HBR_RS_IDLE;
    smm_nxt   = smm_r;
    wr_nxt    = wr_r;
    hit_nxt   = hit_r;
    beats_nxt = beats_r;
    cnt_nxt   = cnt_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    wbv_nxt   = 1'b0;
    wbd_nxt   = wbd_r;
    fv_nxt    = 1'b0;
    fw_nxt    = fw_r;
    sa_nxt    = sa_r;
    sv_nxt    = 1'b0;
    sty_nxt   = sty_r;
    case (st_r)
      HBR_ST_IDLE: begin
        if (fsb.req_valid) begin
          if (spec) begin
            // address phase a not looked at
            sty_nxt = fsb.second_address_phase[15:8];
            sv_nxt  = 1'b1;
            if (fsb.second_address_phase[15:8] == HBR_SC_MGMT_ACK) begin
              smm_nxt = fsb.second_address_phase[HBR_SMM_BIT];
            end
            rs_nxt = HBR_RS_NODATA;
          end else if (i_target_busy) begin
            rs_nxt = HBR_RS_RETRY;
          end else begin
            wr_nxt    = hbr_is_write(fsb.request_code_first_phase);
            // snoop hit only honoured in the snooping variant
            hit_nxt   = SNOOP_VARIANT && fsb.modified_line_hit;
            sa_nxt    = smm_r && fsb.second_address_phase[HBR_SMM_BIT];
            fv_nxt    = !(smm_r && fsb.second_address_phase[HBR_SMM_BIT]);
            fw_nxt    = hbr_is_write(fsb.request_code_first_phase);
            cnt_nxt   = 3'h0;
            if (fsb.request_code_second_phase[1:0] == HBR_LEN_LINE) begin
              beats_nxt = 3'(HBR_LINE_BEATS);
            end else if (zero_len && !hbr_is_write(fsb.request_code_first_phase)) begin
              beats_nxt = 3'h0;
            end else begin
              beats_nxt = 3'h1;
            end
            st_nxt = HBR_ST_DATA;
          end
        end
      end
      HBR_ST_DATA: begin
        if (beats_r == 3'h0) begin
          st_nxt = HBR_ST_RESP;
        end else if (wr_r) begin
          if (fsb.wdata_valid) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r + 3'h1 == beats_r) begin
              st_nxt = HBR_ST_RESP;
            end
          end
        end else begin
          rv_nxt  = !hit_r;
          rd_nxt  = i_target_rdata;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r + 3'h1 == beats_r) begin
            st_nxt = HBR_ST_RESP;
          end
        end
      end
      HBR_ST_RESP: begin
        if (hit_r) begin
          rs_nxt  = HBR_RS_IMPWB;
          cnt_nxt = 3'h0;
          st_nxt  = HBR_ST_REQ;
        end else begin
          // deferred reply never produced
          rs_nxt = wr_r || (beats_r == 3'h0) ? HBR_RS_NODATA : HBR_RS_NORMAL;
          st_nxt = HBR_ST_IDLE;
        end
        sa_nxt = 1'b0;
      end
      HBR_ST_REQ: begin
        // writeback beats follow requester data
        if (fsb.wdata_valid) begin
          wbv_nxt = 1'b1;
          wbd_nxt = fsb.wdata;
          cnt_nxt = cnt_r + 3'h1;
          if ((cnt_r + 3'h1 == beats_r) || (beats_r == 3'h0)) begin
            hit_nxt = 1'b0;
            st_nxt  = HBR_ST_IDLE;
          end
        end
      end
      default: st_nxt = HBR_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r    <= HBR_ST_IDLE;
      rs_r    <= HBR_RS_IDLE;
      smm_r   <= 1'b0;
      wr_r    <= 1'b0;
      hit_r   <= 1'b0;
      beats_r <= 3'h0;
      cnt_r   <= 3'h0;
      rv_r    <= 1'b0;
      rd_r    <= '0;
      wbv_r   <= 1'b0;
      wbd_r   <= '0;
      fv_r    <= 1'b0;
      fw_r    <= 1'b0;
      sa_r    <= 1'b0;
      sv_r    <= 1'b0;
      sty_r   <= 8'h00;
    end else if (i_ce) begin
      st_r    <= st_nxt;
      rs_r    <= rs_nxt;
      smm_r   <= smm_nxt;
      wr_r    <= wr_nxt;
      hit_r   <= hit_nxt;
      beats_r <= beats_nxt;
      cnt_r   <= cnt_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      wbv_r   <= wbv_nxt;
      wbd_r   <= wbd_nxt;
      fv_r    <= fv_nxt;
      fw_r    <= fw_nxt;
      sa_r    <= sa_nxt;
      sv_r    <= sv_nxt;
      sty_r   <= sty_nxt;
    end
  end

  assign fsb.response_status_code = rs_r;
  assign fsb.rdata                = rd_r;
  assign fsb.rdata_valid          = rv_r;
  assign fsb.busy                 = (st_r != HBR_ST_IDLE);
  assign o_smm_open               = smm_r;
  assign o_smm_access             = sa_r;
  assign o_fwd_valid              = fv_r;
  assign o_fwd_write              = fw_r;
  assign o_wb_valid               = wbv_r;
  assign o_wb_data                = wbd_r;
  assign o_special_valid          = sv_r;
  assign o_special_type           = sty_r;
endmodule

// ### rtl/hbr_cpu_agent.sv
`timescale 1ns/1ps
module hbr_cpu_agent
  import hbr_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  // host bus
  hbr_fsb_if.cpu                     fsb,
  // user command
  input  wire logic                  i_cmd_valid,
  input  wire logic [4:0]            i_cmd_code_a,
  input  wire logic [4:0]            i_cmd_code_b,
  input  wire logic [35:3]           i_cmd_addr,
  input  wire logic [15:0]           i_cmd_addr_b,
  input  wire logic                  i_cmd_hit,
  input  wire logic [HBR_DATA_W-1:0] i_cmd_wdata,
  input  wire logic [HBR_DATA_W-1:0] i_cmd_wbdata,
  input  wire logic                  i_enter_smm,
  input  wire logic                  i_exit_smm,
  output logic                       o_cmd_ready,
  output logic                       o_done,
  output logic [2:0]                 o_status,
  output logic [HBR_DATA_W-1:0]      o_rdata,
  output logic                       o_rdata_valid
);
  logic                  pend_r, pend_nxt;
  logic                  rv_r, rv_nxt;
  logic [4:0]            ca_r, ca_nxt;
  logic [4:0]            cb_r, cb_nxt;
  logic [35:3]           ad_r, ad_nxt;
  logic [15:0]           ab_r, ab_nxt;
  logic                  hit_r, hit_nxt;
  logic [HBR_DATA_W-1:0] wd_r, wd_nxt;
  logic [HBR_DATA_W-1:0] wbd_r, wbd_nxt;
  logic                  wbph_r, wbph_nxt;
  logic                  done_r, done_nxt;
  logic [2:0]            st_r, st_nxt;
  logic [HBR_DATA_W-1:0] rd_r, rd_nxt;
  logic                  rdv_r, rdv_nxt;
  logic [2:0]            wcnt_r, wcnt_nxt;

  // beats of one data phase, from the length field
  function automatic logic [2:0] beat_count(input logic [4:0] b);
    return (b[1:0] == HBR_LEN_LINE) ? 3'(HBR_LINE_BEATS) : 3'h1;
  endfunction

  always_comb begin
    pend_nxt = pend_r;
    rv_nxt   = 1'b0;
    ca_nxt   = ca_r;
    cb_nxt   = cb_r;
    ad_nxt   = ad_r;
    ab_nxt   = ab_r;
    hit_nxt  = hit_r;
    wd_nxt   = wd_r;
    wbd_nxt  = wbd_r;
    wbph_nxt = wbph_r;
    done_nxt = 1'b0;
    st_nxt   = st_r;
    rd_nxt   = rd_r;
    rdv_nxt  = 1'b0;
    wcnt_nxt = wcnt_r;
    if (!pend_r && !fsb.busy) begin
      if (i_enter_smm || i_exit_smm) begin
        // management ack special cycle; bit 7 marks entry
        ca_nxt   = HBR_REQA_SPECIAL;
        cb_nxt   = {2'b00, HBR_REQB_SPECIAL};
        ab_nxt   = {HBR_SC_MGMT_ACK, i_enter_smm, 7'h00};
        ad_nxt   = '0;
        hit_nxt  = 1'b0;
        wcnt_nxt = 3'h0;
        pend_nxt = 1'b1;
        rv_nxt   = 1'b1;
      end else if (i_cmd_valid) begin
        // interrupt vectors use the acknowledge code
        ca_nxt   = i_cmd_code_a;
        cb_nxt   = i_cmd_code_b;
        ab_nxt   = i_cmd_addr_b;
        ad_nxt   = i_cmd_addr;
        hit_nxt  = i_cmd_hit;
        wd_nxt   = i_cmd_wdata;
        wbd_nxt  = i_cmd_wbdata;
        wbph_nxt = 1'b0;
        wcnt_nxt = hbr_is_write(i_cmd_code_a) ? beat_count(i_cmd_code_b) : 3'h0;
        pend_nxt = 1'b1;
        rv_nxt   = 1'b1;
      end
    end
    if (fsb.rdata_valid) begin
      rd_nxt  = fsb.rdata;
      rdv_nxt = 1'b1;
    end
    if (fsb.wdata_valid) begin
      wcnt_nxt = wcnt_r - 3'h1;
    end
    if (fsb.response_status_code == HBR_RS_IMPWB) begin
      wbph_nxt = 1'b1;
      wcnt_nxt = beat_count(cb_r);
    end
    if (pend_r && !rv_r && (fsb.response_status_code != HBR_RS_IDLE)
        && !(hit_r && fsb.busy)) begin
      pend_nxt = 1'b0;
      done_nxt = 1'b1;
      st_nxt   = fsb.response_status_code;
    end
    if (pend_r && hit_r && !fsb.busy && wbph_r) begin
      pend_nxt = 1'b0;
      done_nxt = 1'b1;
      st_nxt   = HBR_RS_IMPWB;
      wbph_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= 1'b0;
      rv_r   <= 1'b0;
      ca_r   <= 5'h00;
      cb_r   <= 5'h00;
      ad_r   <= '0;
      ab_r   <= 16'h0000;
      hit_r  <= 1'b0;
      wd_r   <= '0;
      wbd_r  <= '0;
      wbph_r <= 1'b0;
      done_r <= 1'b0;
      st_r   <= HBR_RS_IDLE;
      rd_r   <= '0;
      rdv_r  <= 1'b0;
      wcnt_r <= 3'h0;
    end else if (i_ce) begin
      pend_r <= pend_nxt;
      rv_r   <= rv_nxt;
      ca_r   <= ca_nxt;
      cb_r   <= cb_nxt;
      ad_r   <= ad_nxt;
      ab_r   <= ab_nxt;
      hit_r  <= hit_nxt;
      wd_r   <= wd_nxt;
      wbd_r  <= wbd_nxt;
      wbph_r <= wbph_nxt;
      done_r <= done_nxt;
      st_r   <= st_nxt;
      rd_r   <= rd_nxt;
      rdv_r  <= rdv_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // write data offered while bridge collects beats, writeback data after
  assign fsb.req_valid                 = rv_r;
  assign fsb.request_code_first_phase  = ca_r;
  assign fsb.request_code_second_phase = cb_r;
  assign fsb.first_address_phase       = ad_r;
  assign fsb.second_address_phase      = ab_r;
  assign fsb.locked                    = 1'b0;
  assign fsb.modified_line_hit         = rv_r && hit_r;
  assign fsb.wdata                     = wbph_r ? wbd_r : wd_r;
  // beat counter keeps valid low in the response cycle
  assign fsb.wdata_valid               = pend_r && !rv_r && fsb.busy
                                         && (wcnt_r != 3'h0);
  assign o_cmd_ready                   = !pend_r && !fsb.busy;
  assign o_done                        = done_r;
  assign o_status                      = st_r;
  assign o_rdata                       = rd_r;
  assign o_rdata_valid                 = rdv_r;
endmodule

// ### bench/hbr_fsb_monitor.sv
`timescale 1ns/1ps
module hbr_fsb_monitor
  import hbr_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // host bus
  input  wire logic        req_valid,
  input  wire logic [4:0]  request_code_first_phase,
  input  wire logic [4:0]  request_code_second_phase,
  input  wire logic        modified_line_hit,
  input  wire logic        wdata_valid,
  input  wire logic [2:0]  response_status_code,
  input  wire logic        rdata_valid,
  input  wire logic        busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire logic [2:0] rs   = response_status_code;
  wire logic       take = req_valid && !busy;
  wire logic       spec = (request_code_first_phase == 5'h08)
                          && (request_code_second_phase[2:0] == 3'h1);
  wire logic       wr   = (request_code_first_phase == 5'h11)
                          || (request_code_first_phase == 5'h05)
                          || (request_code_first_phase == 5'h07);
  a_rs_legal_code: assert property (!(rs inside {3'h2, 3'h3, 3'h4}))
    else $error("unused response code driven");
  a_rs_idle_between: assert property (rs != 3'h0 |=> rs == 3'h0)
    else $error("response not back to idle");
  a_special_posted: assert property (take && spec |=> rs == 3'h5)
    else $error("special cycle not ended at once");
  a_special_no_beat: assert property (take && spec |=> !rdata_valid && !wdata_valid)
    else $error("data beat on special cycle");
  a_normal_has_data: assert property (rs == 3'h7 |-> $past(rdata_valid))
    else $error("normal response without read data");
  a_write_gets_nodata: assert property (
    take && wr && !spec && !modified_line_hit |-> ##[1:8] (rs == 3'h5 || rs == 3'h1))
    else $error("write not answered with no data");
  a_hit_gets_writeback: assert property (
    take && !spec && modified_line_hit |-> ##[1:8] rs == 3'h6)
    else $error("modified hit not answered with writeback");
  a_write_no_rdata: assert property (take && wr |=> !rdata_valid [*8])
    else $error("read data on write");
  a_write_data_first: assert property (rs == 3'h6 && wr |-> $past(wdata_valid, 2))
    else $error("writeback response before write data");
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import hbr_pkg::*;
();
  logic        i_clk_sys = 1'b0;
  logic        i_resetn  = 1'b0;
  logic        tbusy     = 1'b0;
  logic        cv = 1'b0, ent = 1'b0, ext = 1'b0, hit = 1'b0;
  logic [4:0]  ca = '0, cb = '0;
  logic [15:0] ab = '0;
  logic [35:3] addr = '1;
  logic [63:0] trd = 64'h1122_3344_5566_7788;
  logic [63:0] wrd = 64'h0f0e_0d0c_0b0a_0908;
  logic [63:0] wbd = 64'ha0b0_c0d0_e0f0_0102;
  wire logic        rdy, done, rdv, smm_open, smm_acc, fwd, fwr, wbv, spv;
  wire logic [2:0]  st;
  wire logic [63:0] rd, wbo;
  wire logic [7:0]  spt;
  int failures = 0, compares = 0, cycles = 0;
  int rd_n, wb_n, fwd_n, fwr_n, sp_n, acc_n, pre_n, post_n, bad_n, after;

  always #25 i_clk_sys = ~i_clk_sys;

  hbr_fsb_if i_hbr_fsb_if();
  hbr_bridge #(.SNOOP_VARIANT(1'b1)) i_hbr_bridge (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(1'b1), .fsb(i_hbr_fsb_if),
    .i_target_busy(tbusy), .i_target_rdata(trd), .o_smm_open(smm_open),
    .o_smm_access(smm_acc), .o_fwd_valid(fwd), .o_fwd_write(fwr), .o_wb_valid(wbv),
    .o_wb_data(wbo), .o_special_valid(spv), .o_special_type(spt));
  hbr_cpu_agent i_hbr_cpu_agent (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(1'b1), .fsb(i_hbr_fsb_if),
    .i_cmd_valid(cv), .i_cmd_code_a(ca), .i_cmd_code_b(cb), .i_cmd_addr(addr),
    .i_cmd_addr_b(ab), .i_cmd_hit(hit), .i_cmd_wdata(wrd), .i_cmd_wbdata(wbd),
    .i_enter_smm(ent), .i_exit_smm(ext), .o_cmd_ready(rdy), .o_done(done),
    .o_status(st), .o_rdata(rd), .o_rdata_valid(rdv));
  hbr_fsb_monitor i_hbr_fsb_monitor (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .req_valid(i_hbr_fsb_if.req_valid),
    .request_code_first_phase(i_hbr_fsb_if.request_code_first_phase),
    .request_code_second_phase(i_hbr_fsb_if.request_code_second_phase),
    .modified_line_hit(i_hbr_fsb_if.modified_line_hit),
    .wdata_valid(i_hbr_fsb_if.wdata_valid),
    .response_status_code(i_hbr_fsb_if.response_status_code),
    .rdata_valid(i_hbr_fsb_if.rdata_valid), .busy(i_hbr_fsb_if.busy));

  task automatic wrap_up();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // pulse counters and bus order watch
  always @(negedge i_clk_sys) begin
    cycles++;
    rd_n  += int'(rdv === 1'b1);
    wb_n  += int'(wbv === 1'b1);
    fwd_n += int'(fwd === 1'b1);
    fwr_n += int'(fwd === 1'b1 && fwr === 1'b1);
    sp_n  += int'(spv === 1'b1);
    acc_n += int'(smm_acc === 1'b1);
    if (rdv === 1'b1 && rd !== trd) bad_n++;
    if (wbv === 1'b1 && wbo !== wbd) bad_n++;
    if (i_hbr_fsb_if.response_status_code === HBR_RS_IMPWB) after = 1;
    if (i_hbr_fsb_if.wdata_valid === 1'b1) begin
      if (after == 0) pre_n++;
      else post_n++;
      if (i_hbr_fsb_if.wdata !== (after == 0 ? wrd : wbd)) bad_n++;
    end
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // sel 0 command, 1 enter management, 2 leave management
  task automatic issue(input int sel, input logic [4:0] a, input logic [4:0] b,
                       input logic [15:0] lanes, input logic h, input logic [2:0] exp);
    int n;
    n = 0;
    {rd_n, wb_n, fwd_n, fwr_n, sp_n, acc_n, pre_n, post_n, bad_n, after} = '0;
    ca = a;
    cb = b;
    ab = lanes;
    hit = h;
    cv = (sel == 0);
    ent = (sel == 1);
    ext = (sel == 2);
    while (rdy !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
    end
    @(posedge i_clk_sys);
    #1;
    {cv, ent, ext} = '0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    chk("done_seen", 1, done);
    chk("status", exp, st);
    repeat (8) @(posedge i_clk_sys);
    #1;
    chk("data_beats", 0, bad_n);
  endtask

  task automatic t_reads();
    issue(0, HBR_REQA_DATARD, 5'h00, 16'hff00, 1'b0, HBR_RS_NORMAL);
    chk("partial_beats", 1, rd_n);
    issue(0, HBR_REQA_CODERD, 5'h02, 16'hff00, 1'b0, HBR_RS_NORMAL);
    chk("line_beats", 4, rd_n);
    issue(0, HBR_REQA_DATARD, 5'h00, 16'h0000, 1'b0, HBR_RS_NODATA);
    chk("zero_len_beats", 0, rd_n);
    issue(0, HBR_REQA_INTACK, {2'b00, HBR_REQB_INTACK}, 16'hff00, 1'b0, HBR_RS_NORMAL);
    chk("intack_beats", 1, rd_n);
    chk("intack_not_special", 0, sp_n);
  endtask

  task automatic t_writes();
    issue(0, HBR_REQA_WR, 5'h02, 16'hff00, 1'b0, HBR_RS_NODATA);
    chk("write_fwd", 1, fwr_n);
    chk("write_rdata", 0, rd_n);
    tbusy = 1'b1;
    issue(0, HBR_REQA_DATARD, 5'h00, 16'hff00, 1'b0, HBR_RS_RETRY);
    issue(0, HBR_REQA_IOWR, 5'h00, 16'h0f00, 1'b0, HBR_RS_RETRY);
    chk("retry_fwd", 0, fwd_n);
    tbusy = 1'b0;
  endtask

  task automatic t_hits();
    issue(0, HBR_REQA_DATARD, 5'h00, 16'hff00, 1'b1, HBR_RS_IMPWB);
    chk("hit_read_wb", 1, wb_n);
    chk("hit_read_rdata", 0, rd_n);
    issue(0, HBR_REQA_WR, 5'h02, 16'hff00, 1'b1, HBR_RS_IMPWB);
    chk("req_beats_first", 4, pre_n);
    chk("wb_beats_after", 4, post_n);
    chk("wb_captured", 4, wb_n);
  endtask

  task automatic t_special();
    addr = '1;
    issue(0, HBR_REQA_SPECIAL, 5'h19, 16'ha500, 1'b0, HBR_RS_NODATA);
    chk("special_seen", 1, sp_n);
    chk("special_type", 8'ha5, spt);
    chk("other_type_smm", 0, smm_open);
    addr = '0;
  endtask

  task automatic t_smm();
    issue(1, '0, '0, '0, 1'b0, HBR_RS_NODATA);
    chk("smm_open", 1, smm_open);
    issue(0, HBR_REQA_DATARD, 5'h00, 16'hff80, 1'b0, HBR_RS_NORMAL);
    chk("smm_fwd", 0, fwd_n);
    chk("smm_access", 1, acc_n > 0);
    issue(2, '0, '0, '0, 1'b0, HBR_RS_NODATA);
    chk("smm_closed", 0, smm_open);
    issue(0, HBR_REQA_DATARD, 5'h00, 16'hff80, 1'b0, HBR_RS_NORMAL);
    chk("closed_fwd", 1, fwd_n);
    chk("closed_access", 0, acc_n);
  endtask

  initial begin
    repeat (20) @(posedge i_clk_sys);
    #1 i_resetn = 1'b1;
    @(posedge i_clk_sys);
    #1;
    t_reads();
    t_writes();
    t_hits();
    t_special();
    t_smm();
    wrap_up();
  end
endmodule
